// >>> hw/dpr_pkg.sv
// Purpose: Shared constants for the defective pixel replacement block
// Assumes: One pixel clock, synchronous active-low reset
// Notes: Pixel depths 8, 10 and 12 sit in the low bits of the pixel word
package dpr_pkg;
	localparam int PIX_W_DEF = 12;
	localparam int COL_W_DEF = 13;
	localparam int ROW_W_DEF = 13;
	localparam int MAX_COLS_DEF = 1024;
	localparam int MAP_ENTRIES_DEF = 16;
	localparam int MAP_BANKS = 2;
	localparam int WIN = 5;
	localparam int CTR = 2;
	localparam int MONO_DIST = 1;
	localparam int MOSAIC_DIST = 2;
	localparam logic MODE_MONO = 1'b0;
	localparam logic MODE_MOSAIC = 1'b1;
	localparam logic BANK_FACTORY = 1'b0;
	localparam logic BANK_USER1 = 1'b1;
	localparam logic FLAG_RST = 1'b0;
endpackage

// >>> hw/defective_pixel_replacement.sv
// Purpose: Replace pixels listed in a bad pixel coordinate map in a pixel stream
// Assumes: Upstream marks frame start and line end; downstream may stall
// Notes: A five-pixel window looks ahead two pixels; the last pixels of a frame
// leave when the next frame starts or when flush_i pushes empty slots in.
// Behaviour
// R1 - Previous bad or absent: take next good
// R2 - Previous good: take previous pixel value
// R3 - Mono, both sides bad: take pixel above
// R4 - No usable neighbour: pass original value
// R5 - Mosaic mode uses only same-colour candidates
// R6 - Entries hold column and row from top-left
// R7 - Same map for 8, 10, 12-bit pixels
// R8 - Entry count is a build-time parameter
// R9 - Factory or user map selects replacement
// R10 - Mosaic neighbours two columns; line buffer above
`timescale 1ns/1ps
module defective_pixel_replacement
	import dpr_pkg::*;
#(
	parameter int PIX_W = dpr_pkg::PIX_W_DEF,
	parameter int COL_W = dpr_pkg::COL_W_DEF,
	parameter int ROW_W = dpr_pkg::ROW_W_DEF,
	parameter int MAX_COLS = dpr_pkg::MAX_COLS_DEF,
	parameter int MAP_ENTRIES = dpr_pkg::MAP_ENTRIES_DEF
)
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Configuration
	input wire logic mode_mosaic_i,
	input wire logic map_sel_user_i,
	// Map load port
	input wire logic map_we_i,
	input wire logic map_bank_i,
	input wire logic [$clog2(MAP_ENTRIES)-1:0] map_idx_i,
	input wire logic map_entry_en_i,
	input wire logic [COL_W-1:0] defect_column_i,
	input wire logic [ROW_W-1:0] defect_row_i,
	// Input stream
	input wire logic in_valid_i,
	input wire logic [PIX_W-1:0] in_pix_i,
	input wire logic in_sof_i,
	input wire logic in_eol_i,
	input wire logic flush_i,
	output logic in_ready_o,
	// Output stream
	output logic out_valid_o,
	output logic [PIX_W-1:0] out_pix_o,
	output logic out_sof_o,
	output logic out_eol_o,
	output logic out_fix_o,
	input wire logic out_ready_i
);
	import dpr_pkg::*;

	// Map storage, one bank per source
	logic [COL_W-1:0] map_col_r [MAP_BANKS][MAP_ENTRIES];
	logic [ROW_W-1:0] map_row_r [MAP_BANKS][MAP_ENTRIES];
	logic map_en_r [MAP_BANKS][MAP_ENTRIES];

	// Look-ahead window, slot CTR is the pixel under decision
	logic [PIX_W-1:0] s_pix_r [WIN];
	logic [COL_W-1:0] s_col_r [WIN];
	logic [ROW_W-1:0] s_row_r [WIN];
	logic s_bad_r [WIN];
	logic s_eol_r [WIN];
	logic s_vld_r [WIN];

	// Previous line, raw value and defect flag per column
	logic [PIX_W-1:0] lb_pix_r [MAX_COLS];
	logic lb_bad_r [MAX_COLS];

	logic [COL_W-1:0] col_r;
	logic [ROW_W-1:0] row_r;
	logic [PIX_W-1:0] skid_pix_r;
	logic skid_sof_r;
	logic skid_eol_r;
	logic skid_fix_r;
	logic skid_vld_r;

	// Search the selected bank for a coordinate
	function automatic logic map_hit(input logic bank, input logic [COL_W-1:0] c,
		input logic [ROW_W-1:0] r);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < MAP_ENTRIES; i++)
		begin
			if (map_en_r[bank][i] && map_col_r[bank][i] == c && map_row_r[bank][i] == r)
			begin
				hit = 1'b1; // R6
			end
		end
		return hit;
	endfunction

	// Candidate slot is on the centre's line and not in the map
	// Slot fields come in as arguments so the wires below follow every change
	function automatic logic slot_good(input logic vld, input logic bad,
		input logic [ROW_W-1:0] row, input logic [ROW_W-1:0] ctr_row);
		return vld && !bad && row == ctr_row;
	endfunction

	localparam int PREV_MONO = CTR - MONO_DIST;
	localparam int NEXT_MONO = CTR + MONO_DIST;
	localparam int PREV_MOSAIC = CTR - MOSAIC_DIST;
	localparam int NEXT_MOSAIC = CTR + MOSAIC_DIST;

	wire logic [COL_W-1:0] in_col = in_sof_i ? '0 : col_r; // R6
	wire logic [ROW_W-1:0] in_row = in_sof_i ? '0 : row_r; // R6
	logic in_bad;
	// A process, not a wire: the search reads map storage that is no argument
	always_comb
	begin
		in_bad = map_hit(map_sel_user_i, in_col, in_row); // R9
	end
	wire logic in_take = in_valid_i && in_ready_o;
	wire logic shift = in_ready_o && (in_valid_i || flush_i);
	wire logic push = shift && s_vld_r[CTR];

	// Mosaic candidates sit two columns away so the filter colour matches
	wire logic prev_ok = mode_mosaic_i
		? slot_good(s_vld_r[PREV_MOSAIC], s_bad_r[PREV_MOSAIC], s_row_r[PREV_MOSAIC],
			s_row_r[CTR])
		: slot_good(s_vld_r[PREV_MONO], s_bad_r[PREV_MONO], s_row_r[PREV_MONO],
			s_row_r[CTR]); // R5 R10
	wire logic next_ok = mode_mosaic_i
		? slot_good(s_vld_r[NEXT_MOSAIC], s_bad_r[NEXT_MOSAIC], s_row_r[NEXT_MOSAIC],
			s_row_r[CTR])
		: slot_good(s_vld_r[NEXT_MONO], s_bad_r[NEXT_MONO], s_row_r[NEXT_MONO],
			s_row_r[CTR]); // R5 R10
	wire logic [PIX_W-1:0] prev_pix = mode_mosaic_i ? s_pix_r[CTR - MOSAIC_DIST]
		: s_pix_r[CTR - MONO_DIST];
	wire logic [PIX_W-1:0] next_pix = mode_mosaic_i ? s_pix_r[CTR + MOSAIC_DIST]
		: s_pix_r[CTR + MONO_DIST];
	wire logic [$clog2(MAX_COLS)-1:0] lb_idx = s_col_r[CTR][$clog2(MAX_COLS)-1:0];
	// Vertical fallback only in mono; mosaic keeps the pixel instead
	wire logic up_ok = !mode_mosaic_i && s_row_r[CTR] != '0 && !lb_bad_r[lb_idx]; // R3 R10
	wire logic ctr_bad = s_bad_r[CTR];
	wire logic use_prev = ctr_bad && prev_ok; // R2
	wire logic use_next = ctr_bad && !prev_ok && next_ok; // R1
	wire logic use_up = ctr_bad && !prev_ok && !next_ok && up_ok; // R3
	wire logic [PIX_W-1:0] fix_pix = use_prev ? prev_pix
		: use_next ? next_pix
		: use_up ? lb_pix_r[lb_idx]
		: s_pix_r[CTR]; // R4
	wire logic fix_done = use_prev || use_next || use_up;
	wire logic push_sof = s_col_r[CTR] == '0 && s_row_r[CTR] == '0;
	wire logic take = !out_valid_o || out_ready_i;

	// Map load; both banks persist, selection applies on the next pixel
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			for (int b = 0; b < MAP_BANKS; b++)
			begin
				for (int i = 0; i < MAP_ENTRIES; i++)
				begin
					map_en_r[b][i] <= FLAG_RST;
					map_col_r[b][i] <= '0;
					map_row_r[b][i] <= '0;
				end
			end
		end
		else if (map_we_i)
		begin
			map_en_r[map_bank_i][map_idx_i] <= map_entry_en_i; // R8 R9
			map_col_r[map_bank_i][map_idx_i] <= defect_column_i; // R6
			map_row_r[map_bank_i][map_idx_i] <= defect_row_i; // R6
		end
	end

	// Position counters
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			col_r <= '0;
			row_r <= '0;
		end
		else if (in_take)
		begin
			col_r <= in_eol_i ? '0 : COL_W'(in_col + 1'b1);
			row_r <= in_eol_i ? ROW_W'(in_row + 1'b1) : in_row;
		end
	end

	// Window shift; flush inserts empty slots to drain the tail
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			for (int k = 0; k < WIN; k++)
			begin
				s_vld_r[k] <= FLAG_RST;
				s_bad_r[k] <= FLAG_RST;
				s_eol_r[k] <= FLAG_RST;
				s_pix_r[k] <= '0;
				s_col_r[k] <= '0;
				s_row_r[k] <= '0;
			end
		end
		else if (shift)
		begin
			for (int k = 0; k < WIN - 1; k++)
			begin
				s_vld_r[k] <= s_vld_r[k + 1];
				s_bad_r[k] <= s_bad_r[k + 1];
				s_eol_r[k] <= s_eol_r[k + 1];
				s_pix_r[k] <= s_pix_r[k + 1];
				s_col_r[k] <= s_col_r[k + 1];
				s_row_r[k] <= s_row_r[k + 1];
			end
			s_vld_r[WIN - 1] <= in_take;
			s_bad_r[WIN - 1] <= in_take && in_bad;
			s_eol_r[WIN - 1] <= in_eol_i;
			s_pix_r[WIN - 1] <= in_pix_i; // R7
			s_col_r[WIN - 1] <= in_col;
			s_row_r[WIN - 1] <= in_row;
		end
	end

	// Line buffer keeps raw values; a replaced value never feeds the next line
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			for (int c = 0; c < MAX_COLS; c++)
			begin
				lb_bad_r[c] <= FLAG_RST;
				lb_pix_r[c] <= '0;
			end
		end
		else if (push)
		begin
			lb_pix_r[lb_idx] <= s_pix_r[CTR]; // R10
			lb_bad_r[lb_idx] <= ctr_bad; // R10
		end
	end

	// Two-entry buffer: output register plus skid register
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			out_valid_o <= FLAG_RST;
			out_pix_o <= '0;
			out_sof_o <= FLAG_RST;
			out_eol_o <= FLAG_RST;
			out_fix_o <= FLAG_RST;
			skid_vld_r <= FLAG_RST;
			skid_pix_r <= '0;
			skid_sof_r <= FLAG_RST;
			skid_eol_r <= FLAG_RST;
			skid_fix_r <= FLAG_RST;
			in_ready_o <= FLAG_RST;
		end
		else
		begin
			if (take && skid_vld_r)
			begin
				out_valid_o <= 1'b1;
				out_pix_o <= skid_pix_r;
				out_sof_o <= skid_sof_r;
				out_eol_o <= skid_eol_r;
				out_fix_o <= skid_fix_r;
				skid_vld_r <= 1'b0;
			end
			else if (take)
			begin
				out_valid_o <= push;
				out_pix_o <= fix_pix;
				out_sof_o <= push_sof;
				out_eol_o <= s_eol_r[CTR];
				out_fix_o <= fix_done;
			end
			else if (push)
			begin
				skid_vld_r <= 1'b1;
				skid_pix_r <= fix_pix;
				skid_sof_r <= push_sof;
				skid_eol_r <= s_eol_r[CTR];
				skid_fix_r <= fix_done;
			end
			// Stall upstream while the skid holds a word
			in_ready_o <= !(skid_vld_r ? !take : (push && !take));
		end
	end

	// Direct path: word pushed into an empty output lands next cycle
	wire logic direct = push && take && !skid_vld_r;

	a_prev_value: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		direct && use_prev |=> out_pix_o == $past(prev_pix) && out_fix_o) // R2
		else $error("previous good pixel not used");
	a_next_value: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		direct && ctr_bad && !prev_ok && next_ok |=> out_pix_o == $past(next_pix)) // R1
		else $error("next good pixel not used");
	a_up_value: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		direct && use_up |=> out_pix_o == $past(lb_pix_r[lb_idx]) && out_fix_o) // R3
		else $error("pixel above not used");
	a_pass_bad: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		direct && ctr_bad && !fix_done |=> out_pix_o == $past(s_pix_r[CTR]) && !out_fix_o) // R4
		else $error("unrepairable pixel altered");
	a_mosaic_no_up: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		direct && mode_mosaic_i && ctr_bad && !prev_ok && !next_ok
		|=> out_pix_o == $past(s_pix_r[CTR]) && !out_fix_o) // R5
		else $error("mosaic used vertical candidate");
	a_mosaic_dist: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		direct && mode_mosaic_i && use_prev |=> out_pix_o == $past(s_pix_r[CTR - MOSAIC_DIST])) // R10
		else $error("mosaic neighbour not two columns away");
	a_map_lookup: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		in_take |=> s_bad_r[WIN - 1] == $past(in_bad)) // R6 R9
		else $error("map flag lost on entry");
	a_good_pass: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		direct && !ctr_bad |=> out_pix_o == $past(s_pix_r[CTR]) && !out_fix_o) // R7
		else $error("good pixel altered");
	a_out_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_pix_o))
		else $error("stalled word dropped");
	a_map_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		map_we_i |=> map_col_r[$past(map_bank_i)][$past(map_idx_i)] == $past(defect_column_i)) // R8
		else $error("map entry not stored");
endmodule

// >>> test/dpr_sink.sv
// Purpose: Downstream formatter model that takes corrected pixels
// Assumes: A word is taken when valid and ready meet at a rising edge
// Notes: Stall mode drops ready every other cycle so the skid buffer fills
`timescale 1ns/1ps
module dpr_sink
(
	// Clock
	input wire logic core_clk_i,
	// Control
	input wire logic stall_i,
	// Stream
	input wire logic valid_i,
	input wire logic [11:0] pix_i,
	input wire logic [2:0] flag_i,
	output logic ready_o
);
	logic [14:0] got_q[$];
	initial ready_o = 1'b1;
	always @(posedge core_clk_i)
	begin
		if (valid_i && ready_o)
			got_q.push_back({flag_i, pix_i});
		ready_o <= stall_i ? !ready_o : 1'b1;
	end
endmodule

// >>> test/defective_pixel_replacement_tb.sv
// Purpose: Self-checking bench for defective pixel replacement
// Assumes: Frames of two lines of six pixels, eight map entries per bank
// Notes: Each scenario loads a map, sends one frame and compares every word
`timescale 1ns/1ps
module defective_pixel_replacement_tb;
	import dpr_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic mode_mosaic_i = MODE_MONO;
	logic map_sel_user_i = BANK_FACTORY;
	logic map_we_i = 1'b0;
	logic map_bank_i = 1'b0;
	logic [2:0] map_idx_i = 3'h0;
	logic map_entry_en_i = 1'b0;
	logic [12:0] defect_column_i = 13'h0;
	logic [12:0] defect_row_i = 13'h0;
	logic in_valid_i = 1'b0;
	logic [11:0] in_pix_i = 12'h0;
	logic in_sof_i = 1'b0;
	logic in_eol_i = 1'b0;
	logic flush_i = 1'b0;
	logic stall = 1'b0;
	logic in_ready_o, out_valid_o, out_sof_o, out_eol_o, out_fix_o, out_ready_i;
	logic [11:0] out_pix_o;
	int failures = 0;
	int n_compared = 0;
	int exp_src[12];
	logic exp_fix[12];
	always #5 core_clk_i = !core_clk_i;
	// Small line buffer keeps the run short
	defective_pixel_replacement #(.MAX_COLS(8), .MAP_ENTRIES(8)) dut (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .mode_mosaic_i(mode_mosaic_i),
		.map_sel_user_i(map_sel_user_i), .map_we_i(map_we_i), .map_bank_i(map_bank_i),
		.map_idx_i(map_idx_i), .map_entry_en_i(map_entry_en_i),
		.defect_column_i(defect_column_i), .defect_row_i(defect_row_i),
		.in_valid_i(in_valid_i), .in_pix_i(in_pix_i), .in_sof_i(in_sof_i),
		.in_eol_i(in_eol_i), .flush_i(flush_i), .in_ready_o(in_ready_o),
		.out_valid_o(out_valid_o), .out_pix_o(out_pix_o), .out_sof_o(out_sof_o),
		.out_eol_o(out_eol_o), .out_fix_o(out_fix_o), .out_ready_i(out_ready_i));
	dpr_sink sink (.core_clk_i(core_clk_i), .stall_i(stall), .valid_i(out_valid_o),
		.pix_i(out_pix_o), .flag_i({out_sof_o, out_eol_o, out_fix_o}), .ready_o(out_ready_i));
	task automatic final_report();
		$display("Compared %0d, failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [14:0] got, input logic [14:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic map_wr(input logic bank, input logic [2:0] idx, input int c, input int r);
		@(posedge core_clk_i);
		map_we_i <= 1'b1;
		map_bank_i <= bank;
		map_idx_i <= idx;
		map_entry_en_i <= 1'b1;
		defect_column_i <= 13'(c);
		defect_row_i <= 13'(r);
		@(posedge core_clk_i);
		map_we_i <= 1'b0;
	endtask
	task automatic exp_clear();
		foreach (exp_src[k])
		begin
			exp_src[k] = k;
			exp_fix[k] = 1'b0;
		end
	endtask
	task automatic rep(input int k, input int src);
		exp_src[k] = src;
		exp_fix[k] = 1'b1;
	endtask
	// Three flush slots push the last pixel out of the look-ahead window
	task automatic run_frame(input logic [11:0] base);
		int k;
		int w;
		logic [14:0] exp_word;
		sink.got_q.delete();
		for (k = 0; k < 15; k++)
		begin
			@(posedge core_clk_i);
			in_valid_i <= (k < 12);
			flush_i <= (k >= 12);
			in_pix_i <= base + 12'((k / 6) * 16 + k % 6);
			in_sof_i <= (k == 0);
			in_eol_i <= (k % 6 == 5);
			w = 0;
			@(negedge core_clk_i);
			while (in_ready_o !== 1'b1 && w < 50)
			begin
				@(negedge core_clk_i);
				w++;
			end
			if (w >= 50)
			begin
				failures++;
				final_report();
			end
		end
		@(posedge core_clk_i);
		in_valid_i <= 1'b0;
		flush_i <= 1'b0;
		w = 0;
		while (sink.got_q.size() < 12 && w < 100)
		begin
			@(posedge core_clk_i);
			w++;
		end
		if (w >= 100)
		begin
			failures++;
			final_report();
		end
		for (k = 0; k < 12; k++)
		begin
			exp_word = {k == 0, k % 6 == 5, exp_fix[k],
				base + 12'((exp_src[k] / 6) * 16 + exp_src[k] % 6)};
			check(sink.got_q[k], exp_word);
		end
	endtask
	task automatic test_mono();
		map_wr(BANK_FACTORY, 3'h0, 0, 0);
		map_wr(BANK_FACTORY, 3'h1, 2, 0);
		map_wr(BANK_FACTORY, 3'h2, 1, 1);
		map_wr(BANK_FACTORY, 3'h3, 2, 1);
		map_wr(BANK_FACTORY, 3'h4, 3, 1);
		map_wr(BANK_FACTORY, 3'h5, 4, 1);
		mode_mosaic_i <= MODE_MONO;
		map_sel_user_i <= BANK_FACTORY;
		stall <= 1'b1;
		exp_clear();
		rep(0, 1);
		rep(2, 1);
		rep(7, 6);
		rep(9, 3);
		rep(10, 11);
		// Index 8 has bad sides and a bad pixel above, so it passes unchanged
		run_frame(12'h100);
		$display("Mono frame test done");
	endtask
	task automatic test_mosaic();
		map_wr(BANK_USER1, 3'h0, 0, 0);
		map_wr(BANK_USER1, 3'h1, 2, 0);
		map_wr(BANK_USER1, 3'h2, 1, 1);
		map_wr(BANK_USER1, 3'h3, 4, 1);
		mode_mosaic_i <= MODE_MOSAIC;
		map_sel_user_i <= BANK_USER1;
		stall <= 1'b0;
		exp_clear();
		rep(2, 4);
		rep(7, 9);
		rep(10, 8);
		// Index 0 has no same-colour candidate left, so it passes unchanged
		run_frame(12'h040);
		$display("Mosaic frame test done");
	endtask
	initial
	begin
		repeat (8) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		test_mono();
		test_mosaic();
		final_report();
	end
endmodule
